// file: core/ipm_mux.sv
// interleaved pcm bus multiplexer for a quad of e1 framers
// assumes: register port on i_clk_sys, backplane bit clock on i_clk_link,
// elastic store write side driven by logic on i_clk_link
//
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module ipm_mux #(
   parameter int NUM_FRAMERS = ipm_pkg::NUM_FRAMERS
) (
   input  wire logic                       i_clk_sys,
   input  wire logic                       i_reset_n,
   input  wire logic [ipm_pkg::ADDR_W-1:0] i_addr,
   input  wire logic [ipm_pkg::DATA_W-1:0] i_wr_data,
   input  wire logic                       i_wr_strobe,
   input  wire logic                       i_rd_strobe,
   output logic      [ipm_pkg::DATA_W-1:0] o_rd_data,
   input  wire logic                       i_clk_link,
   input  wire logic                       i_rx_frame_sync_pin,
   input  wire logic [NUM_FRAMERS-1:0]     i_es_wr_en,
   input  wire logic [ipm_pkg::TS_W-1:0]   i_es_ts,
   input  wire logic [7:0]                 i_es_data,
   input  wire logic [7:0]                 i_es_sig,
   output logic                            o_bus0_data,
   output logic                            o_bus0_sig,
   output logic                            o_bus0_oe,
   output logic                            o_bus1_data,
   output logic                            o_bus1_sig,
   output logic                            o_bus1_oe
);

   localparam int SYNC_L_W = 2 + NUM_FRAMERS * ipm_pkg::CTRL_W;

   // system domain state
   logic [ipm_pkg::CTRL_W-1:0] ctrl_q [NUM_FRAMERS];
   logic [ipm_pkg::DATA_W-1:0] rd_data_q;
   logic [ipm_pkg::DATA_W-1:0] rd_data_d;
   logic [ipm_pkg::DATA_W-1:0] frame_cnt_q;
   logic                       cfg_err_q;
   logic                       cfg_err_d;
   logic                       frame_tog_prev_q;
   logic [1:0]                 from_link_s;

   // link domain state
   logic [SYNC_L_W-1:0]         to_link_s;
   logic [SYNC_L_W-1:0]         to_link_d;
   logic                        link_rst_n;
   logic                        fs_s;
   logic                        fs_prev_q;
   logic                        fs_rise;
   logic [ipm_pkg::CTRL_W-1:0]  cfg_l [NUM_FRAMERS];
   ipm_pkg::ipm_link_state_t    state_q;
   logic [ipm_pkg::POS_W-1:0]   pos_q;
   logic [ipm_pkg::POS_W-1:0]   pos_last;
   logic                        frame_tog_q;
   logic                        lock_l_q;
   logic                        mode4;
   logic [1:0]                  bus_on;
   logic [NUM_FRAMERS-1:0]      en;
   logic [1:0]                  msel [NUM_FRAMERS];
   logic [NUM_FRAMERS-1:0]      drive [2];
   logic [7:0]                  es_data_mem [NUM_FRAMERS][ipm_pkg::TS_PER_FRAME];
   logic [7:0]                  es_sig_mem  [NUM_FRAMERS][ipm_pkg::TS_PER_FRAME];
   logic [1:0]                  bus_data_q;
   logic [1:0]                  bus_sig_q;
   logic [1:0]                  bus_oe_q;

   // control registers, one per framer; upper bits are not stored at all
   generate
      for (genvar f = 0; f < NUM_FRAMERS; f++) begin : g_ctrl
         always_ff @(posedge i_clk_sys) begin
            if (!i_reset_n) begin
               ctrl_q[f] <= ipm_pkg::CTRL_RESET;
            end else if (i_wr_strobe && i_addr == ipm_pkg::ADDR_W'(f)) begin
               ctrl_q[f] <= i_wr_data[ipm_pkg::CTRL_W-1:0];
            end
         end
      end
   endgenerate

   // configuration check: reserved code or a master in a seat that has no bus
   always_comb begin
      logic [1:0] sel;
      sel = 2'h0;
      cfg_err_d = 1'b0;
      for (int f = 0; f < NUM_FRAMERS; f++) begin
         sel = {ctrl_q[f][ipm_pkg::CTRL_MSEL_HI_BIT], ctrl_q[f][ipm_pkg::CTRL_MSEL_LO_BIT]};
         if (sel == ipm_pkg::MSEL_RSVD) begin
            cfg_err_d = 1'b1;
         end
         if (sel == ipm_pkg::MSEL_MASTER_2 && (f % 2) != 0) begin
            cfg_err_d = 1'b1;
         end
         if (sel == ipm_pkg::MSEL_MASTER_4 && f != 0) begin
            cfg_err_d = 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_reset_n) begin
         cfg_err_q <= 1'b0;
      end else begin
         cfg_err_q <= cfg_err_d;
      end
   end

   // frame starts counted from the link's toggle, read by software
   always_ff @(posedge i_clk_sys) begin
      if (!i_reset_n) begin
         frame_tog_prev_q <= 1'b0;
         frame_cnt_q      <= 8'h00;
      end else begin
         frame_tog_prev_q <= from_link_s[1];
         if (from_link_s[1] != frame_tog_prev_q) begin
            frame_cnt_q <= frame_cnt_q + 8'h01;
         end
      end
   end

   // read mux; unmapped offsets and reserved bits read zero
   always_comb begin
      rd_data_d = 8'h00;
      if (i_addr <= ipm_pkg::ADDR_CTRL3) begin
         rd_data_d[ipm_pkg::CTRL_W-1:0] = ctrl_q[i_addr[1:0]];
      end else if (i_addr == ipm_pkg::ADDR_STATUS) begin
         rd_data_d[ipm_pkg::STAT_LOCK_BIT]    = from_link_s[0];
         rd_data_d[ipm_pkg::STAT_CFG_ERR_BIT] = cfg_err_q;
         rd_data_d[ipm_pkg::STAT_MODE4_BIT]   = ctrl_q[0][ipm_pkg::CTRL_EN_BIT] &&
            ({ctrl_q[0][ipm_pkg::CTRL_MSEL_HI_BIT], ctrl_q[0][ipm_pkg::CTRL_MSEL_LO_BIT]}
             == ipm_pkg::MSEL_MASTER_4);
      end else if (i_addr == ipm_pkg::ADDR_FRAME_CNT) begin
         rd_data_d = frame_cnt_q;
      end
   end

   // read data stands for the single cycle after the strobe only
   always_ff @(posedge i_clk_sys) begin
      if (!i_reset_n) begin
         rd_data_q <= 8'h00;
      end else if (i_rd_strobe) begin
         rd_data_q <= rd_data_d;
      end else begin
         rd_data_q <= 8'h00;
      end
   end

   assign o_rd_data = rd_data_q;

   // lock level and frame toggle come back from the link clock
   ipm_sync #(
      .WIDTH (2)
   ) u_sync_sys (
      .i_clk (i_clk_sys),
      .i_d   ({frame_tog_q, lock_l_q}),
      .o_q   (from_link_s)
   );

   // control bits are quasi-static; a write mid-frame may glitch one bit time
   always_comb begin
      to_link_d = '0;
      to_link_d[SYNC_L_W-1] = i_reset_n;
      to_link_d[SYNC_L_W-2] = i_rx_frame_sync_pin;
      for (int f = 0; f < NUM_FRAMERS; f++) begin
         to_link_d[f*ipm_pkg::CTRL_W +: ipm_pkg::CTRL_W] = ctrl_q[f];
      end
   end

   ipm_sync #(
      .WIDTH (SYNC_L_W)
   ) u_sync_link (
      .i_clk (i_clk_link),
      .i_d   (to_link_d),
      .o_q   (to_link_s)
   );

   assign link_rst_n = to_link_s[SYNC_L_W-1];
   assign fs_s       = to_link_s[SYNC_L_W-2];

   // decode each framer's view of the shared bus
   generate
      for (genvar f = 0; f < NUM_FRAMERS; f++) begin : g_cfg
         assign cfg_l[f] = to_link_s[f*ipm_pkg::CTRL_W +: ipm_pkg::CTRL_W];
         assign en[f]    = cfg_l[f][ipm_pkg::CTRL_EN_BIT];
         assign msel[f]  = {cfg_l[f][ipm_pkg::CTRL_MSEL_HI_BIT], cfg_l[f][ipm_pkg::CTRL_MSEL_LO_BIT]};
      end
   endgenerate

   assign mode4     = en[0] && msel[0] == ipm_pkg::MSEL_MASTER_4;
   assign bus_on[0] = mode4 || (en[0] && msel[0] == ipm_pkg::MSEL_MASTER_2);
   assign bus_on[1] = !mode4 && en[2] && msel[2] == ipm_pkg::MSEL_MASTER_2;
   assign pos_last  = mode4 ? ipm_pkg::POS_LAST_HIGH : ipm_pkg::POS_LAST_LOW;
   assign fs_rise   = fs_s && !fs_prev_q;

   always_comb begin
      for (int b = 0; b < 2; b++) begin
         for (int f = 0; f < NUM_FRAMERS; f++) begin
            drive[b][f] = bus_on[b] && en[f] &&
                          (mode4 ? (b == 0) : ((f / 2) == b)) &&
                          (f == 2 * b || msel[f] == ipm_pkg::MSEL_SLAVE);
         end
      end
   end

   // elastic store images; written by the framers on the link clock
   generate
      for (genvar f = 0; f < NUM_FRAMERS; f++) begin : g_es
         always_ff @(posedge i_clk_link) begin
            if (i_es_wr_en[f]) begin
               es_data_mem[f][i_es_ts] <= i_es_data;
               es_sig_mem[f][i_es_ts]  <= i_es_sig;
            end
         end
      end
   endgenerate

   // frame alignment: hunt for the sync edge, then free run and re-align on each
   always_ff @(posedge i_clk_link) begin
      if (!link_rst_n) begin
         state_q     <= ipm_pkg::LS_IDLE;
         pos_q       <= '0;
         fs_prev_q   <= 1'b0;
         frame_tog_q <= 1'b0;
         lock_l_q    <= 1'b0;
      end else begin
         fs_prev_q <= fs_s;
         lock_l_q  <= state_q == ipm_pkg::LS_RUN;
         unique case (state_q)
            ipm_pkg::LS_IDLE: begin
               pos_q <= '0;
               if (bus_on != 2'h0) begin
                  state_q <= ipm_pkg::LS_HUNT;
               end
            end
            ipm_pkg::LS_HUNT: begin
               pos_q <= '0;
               if (bus_on == 2'h0) begin
                  state_q <= ipm_pkg::LS_IDLE;
               end else if (fs_rise) begin
                  state_q     <= ipm_pkg::LS_RUN;
                  pos_q       <= ipm_pkg::POS_W'(1);
                  frame_tog_q <= !frame_tog_q;
               end
            end
            ipm_pkg::LS_RUN: begin
               if (bus_on == 2'h0) begin
                  state_q <= ipm_pkg::LS_IDLE;
                  pos_q   <= '0;
               end else if (fs_rise) begin
                  pos_q       <= ipm_pkg::POS_W'(1);
                  frame_tog_q <= !frame_tog_q;
               end else if (pos_q == pos_last) begin
                  pos_q       <= '0;
                  frame_tog_q <= !frame_tog_q;
               end else begin
                  pos_q <= pos_q + ipm_pkg::POS_W'(1);
               end
            end
         endcase
      end
   end

   // per bus serialiser, msb of each slot first
   generate
      for (genvar b = 0; b < 2; b++) begin : g_bus
         logic [ipm_pkg::FR_W-1:0] fr_loc;
         logic [ipm_pkg::FR_W-1:0] fr;
         logic [ipm_pkg::TS_W-1:0] ts;
         logic [2:0]               bit_n;
         logic                     wide;
         logic                     frame_mode;

         assign wide       = mode4 && b == 0;
         assign frame_mode = cfg_l[2*b][ipm_pkg::CTRL_TYPE_BIT];
         assign bit_n      = 3'h7 - pos_q[2:0];

         always_comb begin
            if (frame_mode) begin
               fr_loc = wide ? pos_q[9:8] : {1'b0, pos_q[8]};
               ts     = pos_q[7:3];
            end else begin
               fr_loc = wide ? pos_q[4:3] : {1'b0, pos_q[3]};
               ts     = wide ? pos_q[9:5] : pos_q[8:4];
            end
            fr = wide ? fr_loc : ipm_pkg::FR_W'(2 * b) + fr_loc;
         end

         always_ff @(posedge i_clk_link) begin
            if (!link_rst_n) begin
               bus_data_q[b] <= 1'b0;
               bus_sig_q[b]  <= 1'b0;
               bus_oe_q[b]   <= 1'b0;
            end else begin
               bus_data_q[b] <= es_data_mem[fr][ts][bit_n];
               bus_sig_q[b]  <= es_sig_mem[fr][ts][bit_n];
               bus_oe_q[b]   <= state_q == ipm_pkg::LS_RUN && drive[b][fr];
            end
         end
      end
   endgenerate

   assign o_bus0_data = bus_data_q[0];
   assign o_bus0_sig  = bus_sig_q[0];
   assign o_bus0_oe   = bus_oe_q[0];
   assign o_bus1_data = bus_data_q[1];
   assign o_bus1_sig  = bus_sig_q[1];
   assign o_bus1_oe   = bus_oe_q[1];

endmodule
`default_nettype wire

// file: core/ipm_pkg.sv
// constants shared by the interleaved pcm bus multiplexer
// assumes: one control register per framer, four framers in the quad
package ipm_pkg;

   // framer and frame geometry
   localparam int NUM_FRAMERS  = 4;
   localparam int TS_PER_FRAME = 32;
   localparam int BITS_PER_TS  = 8;
   localparam int TS_W         = 5;
   localparam int FR_W         = 2;

   // bus rates and how many framers each one carries
   localparam int BASE_RATE_KHZ     = 2048;
   localparam int BUS_RATE_LOW_KHZ  = 4096;
   localparam int BUS_RATE_HIGH_KHZ = 8192;
   localparam int FRAMERS_LOW       = BUS_RATE_LOW_KHZ / BASE_RATE_KHZ;
   localparam int FRAMERS_HIGH      = BUS_RATE_HIGH_KHZ / BASE_RATE_KHZ;
   localparam int FRAME_BITS_LOW    = TS_PER_FRAME * BITS_PER_TS * FRAMERS_LOW;
   localparam int FRAME_BITS_HIGH   = TS_PER_FRAME * BITS_PER_TS * FRAMERS_HIGH;
   localparam int POS_W             = 10;
   localparam logic [POS_W-1:0] POS_LAST_LOW  = POS_W'(FRAME_BITS_LOW - 1);
   localparam logic [POS_W-1:0] POS_LAST_HIGH = POS_W'(FRAME_BITS_HIGH - 1);

   // register port
   localparam int ADDR_W = 3;
   localparam int DATA_W = 8;
   localparam int CTRL_W = 4;
   localparam logic [ADDR_W-1:0] ADDR_CTRL0     = 3'h0;
   localparam logic [ADDR_W-1:0] ADDR_CTRL3     = 3'h3;
   localparam logic [ADDR_W-1:0] ADDR_STATUS    = 3'h4;
   localparam logic [ADDR_W-1:0] ADDR_FRAME_CNT = 3'h5;
   localparam logic [CTRL_W-1:0] CTRL_RESET     = 4'h0;

   // interleave control register fields
   localparam int CTRL_EN_BIT      = 3;
   localparam int CTRL_TYPE_BIT    = 2;
   localparam int CTRL_MSEL_LO_BIT = 1;
   localparam int CTRL_MSEL_HI_BIT = 0;

   // master select codes, written {high, low}
   localparam logic [1:0] MSEL_SLAVE    = 2'h0;
   localparam logic [1:0] MSEL_MASTER_2 = 2'h1;
   localparam logic [1:0] MSEL_MASTER_4 = 2'h2;
   localparam logic [1:0] MSEL_RSVD     = 2'h3;

   // status register fields
   localparam int STAT_LOCK_BIT    = 0;
   localparam int STAT_CFG_ERR_BIT = 1;
   localparam int STAT_MODE4_BIT   = 2;

   typedef enum logic [1:0] {
      LS_IDLE,
      LS_HUNT,
      LS_RUN
   } ipm_link_state_t;

endpackage

// file: core/ipm_sync.sv
// two flip-flop level synchroniser, one per bit
// assumes: each bit is a level that stays put for several destination clocks
`timescale 1ns/10ps
`default_nettype none
module ipm_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             i_clk,
   input  wire logic [WIDTH-1:0] i_d,
   output logic      [WIDTH-1:0] o_q
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   // no reset here: it also carries the reset level itself into the domain
   always_ff @(posedge i_clk) begin
      meta_q <= i_d;
      sync_q <= meta_q;
   end

   assign o_q = sync_q;

endmodule
`default_nettype wire

// file: sim/ipm_mux_asserts.sv
// port checker for the interleaved pcm bus multiplexer
// assumes: bound to every ipm_mux instance, reset seen raw in both domains
`timescale 1ns/10ps
`default_nettype none
module ipm_mux_chk #(
   parameter int NUM_FRAMERS = 4
) (
   input  wire logic       i_clk_sys,
   input  wire logic       i_reset_n,
   input  wire logic [2:0] i_addr,
   input  wire logic [7:0] i_wr_data,
   input  wire logic       i_wr_strobe,
   input  wire logic       i_rd_strobe,
   input  wire logic [7:0] o_rd_data,
   input  wire logic       i_clk_link,
   input  wire logic       o_bus0_oe,
   input  wire logic       o_bus1_oe
);
   rd_idle_zero_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      !i_rd_strobe |=> o_rd_data == 8'h00) else $error("read data not zero while idle");
   unmapped_zero_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      i_rd_strobe && i_addr >= 3'h6 |=> o_rd_data == 8'h00) else $error("unmapped read not zero");
   upper_bits_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      i_rd_strobe && i_addr <= 3'h3 |=> o_rd_data[7:4] == 4'h0) else $error("control upper bits not zero");
   ctrl_readback_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      i_wr_strobe && i_addr <= 3'h3 ##1 i_rd_strobe && !i_wr_strobe && i_addr == $past(i_addr)
      |=> o_rd_data[3:0] == $past(i_wr_data[3:0], 2)) else $error("control readback differs");
   rsvd_err_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      i_wr_strobe && i_addr <= 3'h3 && i_wr_data[1:0] == 2'b11 ##1 !i_wr_strobe
      ##1 i_rd_strobe && i_addr == 3'h4 |=> o_rd_data[1]) else $error("reserved select not flagged");
   odd_master_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      i_wr_strobe && i_addr[0] && i_addr <= 3'h3 && i_wr_data[1:0] == 2'b10 ##1 !i_wr_strobe
      ##1 i_rd_strobe && i_addr == 3'h4 |=> o_rd_data[1]) else $error("odd framer master not flagged");
   bus0_slot_a: assert property (@(posedge i_clk_link) disable iff (!i_reset_n)
      $rose(o_bus0_oe) |=> o_bus0_oe [*7]) else $error("bus0 drive shorter than a byte");
   bus1_slot_a: assert property (@(posedge i_clk_link) disable iff (!i_reset_n)
      $rose(o_bus1_oe) |=> o_bus1_oe [*7]) else $error("bus1 drive shorter than a byte");
endmodule
bind ipm_mux ipm_mux_chk #(.NUM_FRAMERS(NUM_FRAMERS)) chk (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
   .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr_strobe(i_wr_strobe), .i_rd_strobe(i_rd_strobe),
   .o_rd_data(o_rd_data), .i_clk_link(i_clk_link), .o_bus0_oe(o_bus0_oe), .o_bus1_oe(o_bus1_oe));
`default_nettype wire

// file: sim/ipm_far_model.sv
// backplane side: frame sync source and receiver of both shared buses
// assumes: a pull-up on every shared line, i_go raised to start a frame
`timescale 1ns/10ps
`default_nettype none
module ipm_far_model (
   input  wire logic        i_clk_link,
   input  wire logic        i_go,
   input  wire logic [1:0]  i_data,
   input  wire logic [1:0]  i_sig,
   input  wire logic [1:0]  i_oe,
   output logic             o_sync,
   output logic [1:0]       o_data_q,
   output logic [1:0]       o_sig_q,
   output logic [11:0]      o_idx_q
);
   logic        go_q = 1'b0;
   logic [11:0] cnt_q = 12'h000;
   initial o_sync = 1'b0;
   // sync pulse from the one link clock reference
   // released lines float to the pull-up level
   // bit index 0 lands four edges after the pulse, the sync pipe latency
   always @(posedge i_clk_link) begin
      go_q <= i_go;
      o_sync <= i_go && !go_q;
      cnt_q <= (i_go && !go_q) ? 12'h000 : cnt_q + 12'h001;
      o_data_q <= i_data | ~i_oe;
      o_sig_q <= i_sig | ~i_oe;
      o_idx_q <= cnt_q - 12'h003;
   end
endmodule
`default_nettype wire

// file: sim/ipm_mux_bench.sv
// self-checking bench for the interleaved pcm bus multiplexer
// assumes: design files and the far side model compiled first
`timescale 1ns/10ps
`default_nettype none
module ipm_mux_bench;
   logic        clk_sys = 1'b0;
   logic        clk_link = 1'b0;
   logic        reset_n = 1'b0;
   logic [2:0]  addr = 3'h0;
   logic [7:0]  wr_data = 8'h00;
   logic        wr_s = 1'b0;
   logic        rd_s = 1'b0;
   logic [3:0]  es_en = 4'h0;
   logic [4:0]  es_ts = 5'h00;
   logic [7:0]  es_data = 8'h00;
   logic        go = 1'b0;
   logic        m4 = 1'b0;
   logic        ftype = 1'b0;
   logic        chk_on = 1'b0;
   logic [3:0]  en_mask = 4'hF;
   logic [11:0] fl = 12'h200;
   wire  [7:0]  rd_data;
   wire  [1:0]  bdat, bsig, boe, wdat, wsig;
   wire  [11:0] idx;
   wire         fsync;
   int          failures = 0;
   int          tests_run = 0;

   // link clock offset so the two domains never line up
   initial forever #12.5 clk_sys = ~clk_sys;
   initial begin
      #7;
      forever #15 clk_link = ~clk_link;
   end

   ipm_mux uut (.i_clk_sys(clk_sys), .i_reset_n(reset_n), .i_addr(addr), .i_wr_data(wr_data),
      .i_wr_strobe(wr_s), .i_rd_strobe(rd_s), .o_rd_data(rd_data), .i_clk_link(clk_link),
      .i_rx_frame_sync_pin(fsync), .i_es_wr_en(es_en), .i_es_ts(es_ts), .i_es_data(es_data),
      .i_es_sig(~es_data), .o_bus0_data(bdat[0]), .o_bus0_sig(bsig[0]), .o_bus0_oe(boe[0]),
      .o_bus1_data(bdat[1]), .o_bus1_sig(bsig[1]), .o_bus1_oe(boe[1]));
   ipm_far_model far (.i_clk_link(clk_link), .i_go(go), .i_data(bdat), .i_sig(bsig), .i_oe(boe),
      .o_sync(fsync), .o_data_q(wdat), .o_sig_q(wsig), .o_idx_q(idx));

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         failures++;
         if (failures < 20) $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp, input string what);
      chk8({7'h00, got}, {7'h00, exp}, what);
   endtask

   // register master: strobes move just after a rising edge
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      addr <= a;
      wr_data <= d;
      wr_s <= 1'b1;
   endtask
   task automatic idle;
      @(posedge clk_sys);
      wr_s <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] e);
      @(posedge clk_sys);
      addr <= a;
      wr_s <= 1'b0;
      rd_s <= 1'b1;
      @(posedge clk_sys);
      rd_s <= 1'b0;
      #1 chk8(rd_data, e, "register read");
   endtask
   task automatic do_reset;
      @(posedge clk_sys);
      reset_n <= 1'b0;
      wr_s <= 1'b0;
      repeat (5) @(posedge clk_sys);
      reset_n <= 1'b1;
   endtask

   // slot position to expected line level, pull-up where nobody drives
   function automatic logic exp_line(input int b, input logic [11:0] q, input logic s);
      logic [9:0] p;
      logic [1:0] fr;
      logic [4:0] ts;
      logic [7:0] d;
      p = m4 ? q[9:0] : {1'b0, q[8:0]};
      fr = m4 ? (ftype ? p[9:8] : p[4:3]) : {1'b0, ftype ? p[8] : p[3]};
      ts = ftype ? p[7:3] : (m4 ? p[9:5] : p[8:4]);
      if (b == 1) fr = fr + 2'h2;
      d = {fr, 1'b0, ts};
      if (s) d = ~d;
      if (!en_mask[fr] || (m4 && b == 1)) return 1'b1;
      return d[3'h7 - p[2:0]];
   endfunction

   // second frame after the sync pulse is compared bit by bit
   always @(negedge clk_link) begin
      if (chk_on && idx >= fl && idx < 12'(2 * fl)) begin
         chk1(wdat[0], exp_line(0, idx, 1'b0), "bus0 data"); // slot order
         chk1(wsig[0], exp_line(0, idx, 1'b1), "bus0 sig"); // signaling bus
         chk1(wdat[1], exp_line(1, idx, 1'b0), "bus1 data"); // second bus
         chk1(wsig[1], exp_line(1, idx, 1'b1), "bus1 sig"); // second signaling bus
      end
   end

   task automatic t_regs;
      int a;
      do_reset();
      for (a = 0; a < 8; a++) rd(3'(a), 8'h00); // reset values
      wr(3'h1, 8'hFF);
      idle();
      rd(3'h4, 8'h02); // reserved select flagged
      rd(3'h1, 8'h0F); // upper bits dropped
      wr(3'h4, 8'hFF);
      wr(3'h1, 8'h0A);
      idle();
      rd(3'h4, 8'h02); // odd framer master flagged
      wr(3'h1, 8'h0C);
      rd(3'h1, 8'h0C); // frame type stored
      rd(3'h4, 8'h00); // slave code clean
      wr(3'h2, 8'h09);
      idle();
      rd(3'h4, 8'h02); // wide master off framer 0 flagged
      $display("registers test done");
   endtask

   task automatic t_stream(input logic four, input logic frm, input logic [3:0] mask);
      int f;
      int t;
      int n;
      do_reset();
      m4 = four;
      ftype = frm;
      en_mask = mask;
      fl = four ? 12'h400 : 12'h200;
      // elastic stores filled one framer at a time
      for (f = 0; f < 4; f++) for (t = 0; t < 32; t++) begin
         @(posedge clk_link);
         es_en <= 4'(1 << f);
         es_ts <= 5'(t);
         es_data <= {2'(f), 1'b0, 5'(t)};
      end
      @(posedge clk_link);
      es_en <= 4'h0;
      // one master per bus, only framer 0 in four framer mode, upper bits zero
      for (f = 0; f < 4; f++) wr(3'(f), {4'h0, mask[f], frm, !four && !f[0], four && f == 0});
      rd(3'h4, {5'h00, four, 2'b00}); // four framer mode flag
      @(posedge clk_sys);
      go <= 1'b1;
      repeat (3) @(posedge clk_link);
      chk_on = 1'b1;
      for (n = 0; n < 4000 && idx != 12'(2 * fl); n++) @(posedge clk_link);
      chk_on = 1'b0;
      chk1(idx == 12'(2 * fl), 1'b1, "checked frame not reached in time"); // bounded frame wait
      @(posedge clk_sys);
      go <= 1'b0;
      rd(3'h4, {5'h00, four, 2'b01}); // bus locked and running
      $display("stream test done four=%0d frame=%0d", four, frm);
   endtask

   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   initial begin
      t_regs();
      t_stream(1'b0, 1'b0, 4'hF); // byte slots
      t_stream(1'b0, 1'b1, 4'h7); // frame slots, one framer off
      t_stream(1'b1, 1'b0, 4'hF); // four framers bytes
      t_stream(1'b1, 1'b1, 4'hF); // four framers frames
      report_and_stop();
   end

   // watchdog: the whole run needs well under a third of this
   initial begin
      #1000000;
      failures++;
      report_and_stop();
   end
endmodule
`default_nettype wire
